// ==== src/dcse_top.sv ====
// Dual-channel safety input evaluator with Wishbone registers
//
// Added by the designer: register access over Wishbone and the register addresses.
`include "dcse_consts.svh"
`default_nettype none
module dcse_top #(
	parameter int TW = 16,
	parameter int STEP_CYC = `DCSE_STEP_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Safety channels (pins)
	input wire logic [1:0] p1_ch_i,
	input wire logic [1:0] p2_ch_i,
	input wire logic proof_req_i,
	// Results
	output logic enable_o,
	output logic sync_err_o,
	output logic seq_err_o,
	output logic proof_pend_o,
	output logic proof_err_o,
	output logic irq_o
);
	import dcse_pkg::*;

	// Refuse a timer too narrow for the longest window, or a step of no cycles
	if (TW < 12 || STEP_CYC < 1) begin : g_bad_param
		$error("dcse_top: TW must be at least 12, STEP_CYC at least 1");
	end

	//------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------
	logic [4:0] meta_ff, sync_ff;
	// Only the second stage feeds logic; the first may still be settling
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= 5'h00;
			sync_ff <= 5'h00;
		end else begin
			meta_ff <= {proof_req_i, p2_ch_i, p1_ch_i};
			sync_ff <= meta_ff;
		end
	end

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	logic [31:0] ctrl_ff;
	logic [TW-1:0] sync1_ff, sync2_ff;
	logic [`DCSE_NEV-1:0] irq_ff, mask_ff, nxt_irq;
	logic ack_ff;
	logic [31:0] dat_ff;

	wire logic req = cyc_i & stb_i & ~ack_ff;
	wire logic wr = req & we_i;
	wire logic rd = req & ~we_i;
	wire logic [2:0] mode_raw = ctrl_ff[`DCSE_CTRL_MODE_LO +: 3];
	wire logic [1:0] var_raw = ctrl_ff[`DCSE_CTRL_VAR_LO +: 2];
	wire logic run = ctrl_ff[`DCSE_CTRL_RUN];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Registers read back as written; only the timers see the clamped value
	// Clamp a sync time to the variant's range in 10 ms steps
	function automatic logic [TW-1:0] clamp(input logic [TW-1:0] t, input logic [1:0] v);
		logic [TW-1:0] r;
		r = t;
		case (v)
			DCSE_SOLENOID: begin
				// Mandatory window, no disabled setting
				if (t == '0) r = TW'(1);
				else if (t > TW'(`DCSE_SOL_MAX)) r = TW'(`DCSE_SOL_MAX);
			end
			DCSE_GRID: if (t > TW'(`DCSE_GRID_MAX)) r = TW'(`DCSE_GRID_MAX);
			default: if (t > TW'(`DCSE_ESTOP_MAX)) r = TW'(`DCSE_ESTOP_MAX);
		endcase
		return r;
	endfunction

	// Variant restricts the offered modes
	logic [2:0] mode;
	always_comb begin
		case (var_raw)
			DCSE_SOLENOID: mode = (mode_raw == DCSE_DIS1) ? DCSE_DIS1 : DCSE_EQ1;
			DCSE_GRID: mode = DCSE_EQ1;
			DCSE_SWITCH: mode = (mode_raw > DCSE_DIS2) ? DCSE_SINGLE : mode_raw;
			default: mode = (mode_raw > DCSE_DIS1) ? DCSE_SINGLE : mode_raw;
		endcase
	end
	wire logic two_ch = (mode != DCSE_SINGLE);
	wire logic inv = (mode == DCSE_DIS1) || (mode == DCSE_DIS2);
	wire logic use_p2 = (mode == DCSE_EQ2) || (mode == DCSE_DIS2);
	wire logic proof_on = (var_raw == DCSE_SWITCH) && ctrl_ff[`DCSE_CTRL_PROOF];
	wire logic intlk = ctrl_ff[`DCSE_CTRL_INTLK] && (var_raw != DCSE_SWITCH);
	wire logic [TW-1:0] t1 = clamp(sync1_ff, var_raw);
	wire logic [TW-1:0] t2 = clamp(sync2_ff, var_raw);

	//------------------------------------------------------------
	// Timebase and run edge
	//------------------------------------------------------------
	// A window is known to one step only; the divider runs free of the pairs
	logic [31:0] div_ff;
	logic run_ff, preq_ff;
	wire logic tick = (div_ff == 32'(STEP_CYC - 1));
	wire logic startup = run & ~run_ff;
	wire logic preq_rise = sync_ff[4] & ~preq_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_ff <= 32'h0000_0000;
			run_ff <= 1'b0;
			preq_ff <= 1'b0;
		end else begin
			div_ff <= tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
			run_ff <= run;
			preq_ff <= sync_ff[4];
		end
	end

	//------------------------------------------------------------
	// Pairs
	//------------------------------------------------------------
	// Both pairs share mode and timebase; pair 2 counts only in two-pair modes
	logic [1:0] ev, se, qe;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pair
			dcse_pair #(.TW(TW)) u_pair (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.tick_i(tick),
				.two_ch_i(two_ch),
				.inv_i(inv),
				.sync_i(g == 0 ? t1 : t2),
				.startup_i(startup | ~run),
				.intlk_i(intlk),
				.ch_a_i(g == 0 ? sync_ff[0] : sync_ff[2]),
				.ch_b_i(g == 0 ? sync_ff[1] : sync_ff[3]),
				.eval_o(ev[g]),
				.sync_err_o(se[g]),
				.seq_err_o(qe[g])
			);
		end
	endgenerate

	wire logic comb_eval = run & ev[0] & (~use_p2 | ev[1]);
	wire logic any_sync = se[0] | (use_p2 & se[1]);
	wire logic any_seq = qe[0] | (use_p2 & qe[1]);

	//------------------------------------------------------------
	// Proof check and outputs
	//------------------------------------------------------------
	logic en_ff, pend_ff, perr_ff, serr_ff, qerr_ff, ok_ff;
	// A proof fault clears on a fresh rise of the evaluation, so the fault
	// itself must not hold back the rise that is meant to clear it
	wire logic seq_ok = comb_eval & ~any_sync & ~any_seq;
	wire logic ok_rise = seq_ok & ~ok_ff;
	wire logic nxt_en = seq_ok
		& ~(proof_on & ((perr_ff & ~ok_rise) | (pend_ff & preq_rise)));
	wire logic en_rise = nxt_en & ~en_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_ff <= 1'b0;
			pend_ff <= 1'b0;
			perr_ff <= 1'b0;
			serr_ff <= 1'b0;
			qerr_ff <= 1'b0;
			ok_ff <= 1'b0;
		end else begin
			en_ff <= nxt_en;
			serr_ff <= any_sync;
			qerr_ff <= any_seq;
			ok_ff <= seq_ok;
			if (!proof_on) begin
				pend_ff <= 1'b0;
				perr_ff <= 1'b0;
			end else begin
				if (startup || preq_rise) pend_ff <= 1'b1;
				else if (en_rise) pend_ff <= 1'b0;
				if (pend_ff && preq_rise) perr_ff <= 1'b1;
				else if (en_rise) perr_ff <= 1'b0;
			end
		end
	end
	// Registered outputs, so a settling channel never glitches a pin
	assign enable_o = en_ff;
	assign sync_err_o = serr_ff;
	assign seq_err_o = qerr_ff;
	assign proof_pend_o = pend_ff;
	assign proof_err_o = perr_ff;

	//------------------------------------------------------------
	// Bus slave and interrupts
	//------------------------------------------------------------
	// Each event fires once, in the cycle before its flag shows
	wire logic [`DCSE_NEV-1:0] evt = {en_rise, proof_on & pend_ff & preq_rise,
		any_seq & ~qerr_ff, any_sync & ~serr_ff};
	wire logic rd_irq = rd && (adr_i == `DCSE_REG_IRQ);
	always_comb begin
		// Set wins over the clear-on-read
		nxt_irq = (rd_irq ? '0 : irq_ff) | evt;
	end
	wire logic [31:0] rdata =
		(adr_i == `DCSE_REG_CTRL) ? ctrl_ff :
		(adr_i == `DCSE_REG_SYNC1) ? 32'(sync1_ff) :
		(adr_i == `DCSE_REG_SYNC2) ? 32'(sync2_ff) :
		(adr_i == `DCSE_REG_STAT) ? {27'h0, perr_ff, pend_ff, qerr_ff, serr_ff, en_ff} :
		(adr_i == `DCSE_REG_IRQ) ? 32'(irq_ff) :
		(adr_i == `DCSE_REG_MASK) ? 32'(mask_ff) : 32'h0000_0000;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= `DCSE_CTRL_RST;
			sync1_ff <= '0;
			sync2_ff <= '0;
			irq_ff <= '0;
			mask_ff <= '0;
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= req;
			irq_ff <= nxt_irq;
			if (rd) dat_ff <= rdata;
			if (wr && adr_i == `DCSE_REG_CTRL) ctrl_ff <= merge(ctrl_ff, dat_i, sel_i);
			if (wr && adr_i == `DCSE_REG_SYNC1) sync1_ff <= TW'(merge(32'(sync1_ff), dat_i, sel_i));
			if (wr && adr_i == `DCSE_REG_SYNC2) sync2_ff <= TW'(merge(32'(sync2_ff), dat_i, sel_i));
			if (wr && adr_i == `DCSE_REG_MASK) mask_ff <= `DCSE_NEV'(dat_i);
		end
	end
	assign ack_o = ack_ff;
	assign dat_o = dat_ff;
	assign irq_o = |(irq_ff & mask_ff);

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	sequence s_second_request;
		proof_on && pend_ff && preq_rise;
	endsequence
	sequence s_fault_shown;
		perr_ff && !en_ff;
	endsequence

	// Bus handshake
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_ff) |=> ack_ff) else $error("ack missing");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_ff |=> !ack_ff) else $error("ack longer than one cycle");
	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && adr_i > `DCSE_REG_MASK) |=> (dat_o == 32'h0)) else $error("unmapped read");

	// Proof check
	a_proof_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		s_second_request |=> s_fault_shown) else $error("proof fault");
	a_proof_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		s_second_request |=> irq_ff[`DCSE_EV_PROOF]) else $error("proof event lost");
	a_proof_pend: assert property (@(posedge clk_i) disable iff (rst_i)
		(proof_on && preq_rise) |=> pend_ff) else $error("proof pending");
	a_pend_run: assert property (@(posedge clk_i) disable iff (rst_i)
		(proof_on && startup) |=> pend_ff) else $error("pending after run");
	a_pend_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(proof_on && en_rise && !startup && !preq_rise) |=> !pend_ff) else $error("pending kept");
	a_perr_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(proof_on && perr_ff && en_rise) |=> !perr_ff) else $error("proof fault kept");

	// Enable and errors
	a_en_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		en_ff |-> $past(comb_eval)) else $error("enable without eval");
	a_err_en_low: assert property (@(posedge clk_i) disable iff (rst_i)
		(any_sync || any_seq) |=> !en_ff) else $error("enable with error");
	a_run_off_en: assert property (@(posedge clk_i) disable iff (rst_i)
		!run |=> !en_ff) else $error("enable while stopped");
	a_en_rise_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		en_rise |=> irq_ff[`DCSE_EV_EN]) else $error("enable event lost");

	// Events
	a_irq_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		(|evt) |=> ((irq_ff & $past(evt)) == $past(evt))) else $error("event lost");
	a_seq_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		(any_seq && !qerr_ff) |=> irq_ff[`DCSE_EV_SEQ]) else $error("sequence event lost");
	a_sync_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		(any_sync && !serr_ff) |=> irq_ff[`DCSE_EV_SYNC]) else $error("sync event lost");

	// Variant limits
	a_grid_mode: assert property (@(posedge clk_i) disable iff (rst_i)
		(var_raw == DCSE_GRID) |-> (mode == DCSE_EQ1)) else $error("grid mode");
	a_sol_window: assert property (@(posedge clk_i) disable iff (rst_i)
		(var_raw == DCSE_SOLENOID) |-> (t1 != '0 && t2 != '0 && t1 <= TW'(`DCSE_SOL_MAX)
		&& t2 <= TW'(`DCSE_SOL_MAX))) else $error("solenoid window");
	a_grid_window: assert property (@(posedge clk_i) disable iff (rst_i)
		(var_raw == DCSE_GRID) |-> (t1 <= TW'(`DCSE_GRID_MAX) && t2 <= TW'(`DCSE_GRID_MAX)))
		else $error("grid window");
endmodule
`default_nettype wire

// ==== src/dcse_consts.svh ====
// Constants of the dual-channel safety input evaluator
//------------------------------------------------------------
// Behaviour
// - Five input modes, variant limits the choice
// - Fault output on bad combination or sequence
// - Sync time: both rise within sync time
// - Start interlock: both high at startup, no enable; not applied in the switch variant
// - Enable follows combined channel evaluation
// - Emergency stop: single, EQ1 or DIS1 mode, time 0 or 10-30000
// - Three outputs: enable, sync error, sequence error
// - Solenoid: two-channel only, time 10-3000 mandatory
// - Light grid: two-channel equivalent only
// - Light grid: time 0 or 10-500 ms
// - Switch variant: one pair or two pairs
// - Switch variant: optional proof check monitoring
// - Proof pending set on run and request edge
// - Request edge while pending: fault, enable low
//------------------------------------------------------------
`ifndef DCSE_CONSTS_SVH
`define DCSE_CONSTS_SVH

// Register byte offsets
`define DCSE_REG_CTRL 8'h00
`define DCSE_REG_SYNC1 8'h04
`define DCSE_REG_SYNC2 8'h08
`define DCSE_REG_STAT 8'h0C
`define DCSE_REG_IRQ 8'h10
`define DCSE_REG_MASK 8'h14

// Control fields
`define DCSE_CTRL_MODE_LO 0
`define DCSE_CTRL_VAR_LO 3
`define DCSE_CTRL_INTLK 5
`define DCSE_CTRL_PROOF 6
`define DCSE_CTRL_RUN 7
`define DCSE_CTRL_RST 32'h0000_0000

// Timing: sync time in units of 10 ms
`define DCSE_STEP_MS 10
`define DCSE_CLK_HZ 50000000
`define DCSE_STEP_CYC (`DCSE_CLK_HZ / 1000 * `DCSE_STEP_MS)
`define DCSE_ESTOP_MAX 16'd3000
`define DCSE_SOL_MAX 16'd300
`define DCSE_GRID_MAX 16'd50

// Event bits
`define DCSE_EV_SYNC 0
`define DCSE_EV_SEQ 1
`define DCSE_EV_PROOF 2
`define DCSE_EV_EN 3
`define DCSE_NEV 4

`endif

// ==== src/dcse_pkg.sv ====
// Types of the dual-channel safety input evaluator
`default_nettype none
package dcse_pkg;
	typedef enum logic [2:0] {
		DCSE_SINGLE = 3'h0,
		DCSE_EQ1 = 3'h1,
		DCSE_DIS1 = 3'h2,
		DCSE_EQ2 = 3'h3,
		DCSE_DIS2 = 3'h4
	} dcse_mode_t;
	typedef enum logic [1:0] {
		DCSE_ESTOP = 2'h0,
		DCSE_SOLENOID = 2'h1,
		DCSE_GRID = 2'h2,
		DCSE_SWITCH = 2'h3
	} dcse_var_t;
	typedef enum logic [1:0] {
		DCSE_OFF = 2'b00,
		DCSE_WAIT = 2'b01,
		DCSE_ON = 2'b11,
		DCSE_LOCK = 2'b10
	} dcse_pair_st_t;
endpackage
`default_nettype wire

// ==== src/dcse_pair.sv ====
// One two-channel pair: synchronous time and sequence check
`include "dcse_consts.svh"
`default_nettype none
module dcse_pair #(
	parameter int TW = 16
) (
	// Clock, reset and step tick
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	// Configuration
	input wire logic two_ch_i,
	input wire logic inv_i,
	input wire logic [TW-1:0] sync_i,
	input wire logic startup_i,
	input wire logic intlk_i,
	// Channels, already synchronised
	input wire logic ch_a_i,
	input wire logic ch_b_i,
	// Result
	output logic eval_o,
	output logic sync_err_o,
	output logic seq_err_o
);
	import dcse_pkg::*;

	dcse_pair_st_t st_ff, nxt_st;
	logic [TW-1:0] cnt_ff, nxt_cnt;
	logic sync_err_ff, nxt_sync_err;
	logic seq_err_ff, nxt_seq_err;

	wire logic b_eff = two_ch_i ? (ch_b_i ^ inv_i) : ch_a_i;
	wire logic both_hi = ch_a_i & b_eff;
	wire logic both_lo = ~ch_a_i & ~b_eff;
	wire logic one_hi = ch_a_i ^ b_eff;
	wire logic timed = (sync_i != '0);
	wire logic expired = timed && tick_i && (cnt_ff + TW'(1) >= sync_i);

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sync_err = sync_err_ff;
		nxt_seq_err = seq_err_ff;
		if (startup_i) begin
			// Already high at startup under interlock: no enable
			nxt_st = (intlk_i && both_hi) ? DCSE_LOCK : DCSE_OFF;
			nxt_cnt = '0;
		end else begin
			case (st_ff)
				DCSE_OFF: begin
					nxt_cnt = '0;
					if (both_hi && !sync_err_ff && !seq_err_ff) begin
						nxt_st = DCSE_ON;
					end else if (one_hi) begin
						nxt_st = DCSE_WAIT;
					end else if (both_lo) begin
						// Valid sequence restarts from both low
						nxt_sync_err = 1'b0;
						nxt_seq_err = 1'b0;
					end
				end
				DCSE_WAIT: begin
					if (tick_i) begin
						nxt_cnt = cnt_ff + TW'(1);
					end
					if (both_lo) begin
						nxt_st = DCSE_OFF;
					end else if (both_hi) begin
						// Partner followed within the window
						nxt_st = (sync_err_ff || seq_err_ff) ? DCSE_OFF : DCSE_ON;
					end else if (expired) begin
						nxt_sync_err = 1'b1;
						nxt_st = DCSE_LOCK;
					end
				end
				DCSE_ON: begin
					if (!both_hi) begin
						nxt_st = both_lo ? DCSE_OFF : DCSE_LOCK;
					end
				end
				DCSE_LOCK: begin
					// Besides a stop or startup, only a return of both to low re-arms the pair
					if (both_lo) begin
						nxt_st = DCSE_OFF;
					end else if (both_hi && !intlk_i) begin
						nxt_seq_err = 1'b1;
					end
				end
				default: nxt_st = DCSE_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= DCSE_OFF;
			cnt_ff <= '0;
			sync_err_ff <= 1'b0;
			seq_err_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sync_err_ff <= nxt_sync_err;
			seq_err_ff <= nxt_seq_err;
		end
	end

	assign eval_o = (st_ff == DCSE_ON);
	assign sync_err_o = sync_err_ff;
	assign seq_err_o = seq_err_ff;

	a_err_blocks_en: assert property (@(posedge clk_i) disable iff (rst_i)
		(sync_err_ff || seq_err_ff) |-> !eval_o) else $error("enable with error");
	a_sync_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_ff == DCSE_WAIT && expired && !both_lo && !both_hi && !startup_i)
		|=> sync_err_ff) else $error("sync error missed");
	a_lock_startup: assert property (@(posedge clk_i) disable iff (rst_i)
		(startup_i && intlk_i && both_hi) |=> !eval_o [*2]) else $error("startup lock");
endmodule
`default_nettype wire

// ==== sim/dcse_switch_model.sv ====
// Behavioural model of two contact pairs and the machine cycle contact
`default_nettype none
module dcse_switch_model (
	// Clock
	input wire logic clk_i,
	// Contacts
	output var logic [1:0] p1_ch_o,
	output var logic [1:0] p2_ch_o,
	output var logic proof_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		p1_ch_o = 2'h0;
		p2_ch_o = 2'h0;
		proof_req_o = 1'b0;
	end
	// Channel A moves first; B lags by skew cycles, as a slow contact would
	task automatic move(input logic [1:0] t1, input logic [1:0] t2, input int skew);
		@(posedge clk_i);
		if (skew == 0) begin
			p1_ch_o <= t1;
			p2_ch_o <= t2;
		end else begin
			p1_ch_o[0] <= t1[0];
			p2_ch_o[0] <= t2[0];
			repeat (skew) @(posedge clk_i);
			p1_ch_o[1] <= t1[1];
			p2_ch_o[1] <= t2[1];
		end
		repeat (8) @(posedge clk_i);
	endtask
	// Pulse wide enough to pass the input synchronisers
	task automatic cycle_pulse();
		@(posedge clk_i);
		proof_req_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		proof_req_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ==== sim/dcse_top_bench.sv ====
// Self-checking bench of the dual-channel safety input evaluator
`include "dcse_consts.svh"
`default_nettype none
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
	$display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module dcse_top_bench import dcse_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, rdat;
	logic ack_o, enable_o, sync_err_o, seq_err_o, proof_pend_o, proof_err_o, irq_o;
	wire logic [1:0] p1_ch, p2_ch;
	wire logic proof_req;
	int failures = 0;
	int cmp_count = 0;
	dcse_mode_t md_tab[5] = '{DCSE_SINGLE, DCSE_EQ1, DCSE_DIS1, DCSE_EQ2, DCSE_DIS2};
	logic [1:0] on_tab[5] = '{2'h1, 2'h3, 2'h1, 2'h3, 2'h1};
	logic [1:0] off_tab[5] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h2};

	always #10 clk_i = ~clk_i;

	// Short step so one sync unit is 10 cycles
	dcse_top #(.TW(16), .STEP_CYC(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .p1_ch_i(p1_ch), .p2_ch_i(p2_ch),
		.proof_req_i(proof_req), .enable_o(enable_o), .sync_err_o(sync_err_o),
		.seq_err_o(seq_err_o), .proof_pend_o(proof_pend_o), .proof_err_o(proof_err_o),
		.irq_o(irq_o));
	dcse_switch_model i_part (.clk_i(clk_i), .p1_ch_o(p1_ch), .p2_ch_o(p2_ch),
		.proof_req_o(proof_req));

	// ----------------------------------------
	// Bus access
	// ----------------------------------------
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		// Hold the request until the edge that samples ack; data is taken there
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		`CHK("bus ack", 1'b1, ack_o)
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, a, d, q);
	endtask
	task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
		wb_cycle(1'b0, a, 32'h0, q);
	endtask
	task automatic wait_stat(input int b, input logic v, input string what);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			wb_read(`DCSE_REG_STAT, q);
			n++;
		end while (q[b] !== v && n < 100);
		`CHK(what, v, q[b])
	endtask
	// Stop then run, so every configuration starts from a fresh startup
	task automatic cfg(input dcse_mode_t md, input dcse_var_t vr, input logic lk, input logic pf);
		wb_write(`DCSE_REG_CTRL, {24'h0, 1'b0, pf, lk, vr, md});
		wb_write(`DCSE_REG_CTRL, {24'h0, 1'b1, pf, lk, vr, md});
	endtask
	task automatic give_verdict();
		$display("%0d comparisons, %0d mismatches", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		failures++;
		give_verdict();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_read(`DCSE_REG_STAT, rdat);
		`CHK("status after reset", 32'h0, rdat)
		wb_read(8'h3C, rdat);
		`CHK("unmapped read", 32'h0, rdat)
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			i_part.move(off_tab[i], off_tab[i], 0);
			cfg(md_tab[i], DCSE_SWITCH, 1'b0, 1'b0);
			i_part.move(on_tab[i], on_tab[i], 0);
			wait_stat(0, 1'b1, "enable on");
			`CHK("enable pin", 1'b1, enable_o)
			i_part.move(off_tab[i], off_tab[i], 0);
			wait_stat(0, 1'b0, "enable off");
		end
		$display("test modes done");
		i_part.move(2'h0, 2'h0, 0);
		cfg(DCSE_EQ1, DCSE_ESTOP, 1'b0, 1'b0);
		wb_write(`DCSE_REG_SYNC1, 32'h2);
		wb_write(`DCSE_REG_SYNC2, 32'h2);
		wb_write(`DCSE_REG_MASK, 32'h0);
		i_part.move(2'h3, 2'h3, 60);
		wait_stat(1, 1'b1, "sync error");
		`CHK("seq error", 1'b1, seq_err_o)
		`CHK("enable held", 1'b0, enable_o)
		`CHK("irq masked", 1'b0, irq_o)
		wb_write(`DCSE_REG_MASK, 32'h1);
		`CHK("irq unmasked", 1'b1, irq_o)
		wb_read(`DCSE_REG_IRQ, rdat);
		`CHK("irq sync bit", 1'b1, rdat[0])
		repeat (2) @(posedge clk_i);
		`CHK("irq cleared", 1'b0, irq_o)
		i_part.move(2'h0, 2'h0, 0);
		i_part.move(2'h3, 2'h3, 0);
		wait_stat(0, 1'b1, "enable again");
		`CHK("sync error gone", 1'b0, sync_err_o)
		$display("test sync time done");
		cfg(DCSE_EQ1, DCSE_ESTOP, 1'b1, 1'b0);
		repeat (60) @(posedge clk_i);
		`CHK("enable locked", 1'b0, enable_o)
		i_part.move(2'h0, 2'h0, 0);
		i_part.move(2'h3, 2'h3, 5);
		wait_stat(0, 1'b1, "enable unlocked");
		$display("test interlock done");
		i_part.move(2'h0, 2'h0, 0);
		cfg(DCSE_EQ1, DCSE_SWITCH, 1'b0, 1'b1);
		wait_stat(3, 1'b1, "pending after run");
		i_part.move(2'h3, 2'h3, 0);
		wait_stat(3, 1'b0, "pending done");
		i_part.cycle_pulse();
		wait_stat(3, 1'b1, "pending after edge");
		`CHK("pending pin", 1'b1, proof_pend_o)
		i_part.cycle_pulse();
		wait_stat(4, 1'b1, "proof fault");
		`CHK("enable on fault", 1'b0, enable_o)
		wb_read(`DCSE_REG_IRQ, rdat);
		`CHK("irq proof bit", 1'b1, rdat[2])
		i_part.move(2'h0, 2'h0, 0);
		i_part.move(2'h3, 2'h3, 0);
		wait_stat(0, 1'b1, "enable after proof");
		`CHK("proof fault gone", 1'b0, proof_err_o)
		$display("test proof check done");
		give_verdict();
	end
endmodule
`default_nettype wire
